/* shared/wwd_pkg.sv */
package wwd_pkg;
	localparam int CLK_HZ = 100_000_000;
	localparam int TICK_US = 10;
	localparam int TICK_CYCLES = TICK_US * (CLK_HZ / 1_000_000);
	localparam int PULSE_MIN_US = 10;
	localparam int PULSE_MAX_US = 5000;
	localparam int PULSE_MIN_TICKS = (PULSE_MIN_US + TICK_US - 1) / TICK_US;
	localparam int PULSE_MAX_TICKS = PULSE_MAX_US / TICK_US;
	localparam int T0_TICKS = 1000;
	localparam int T1_TICKS = 5000;
	localparam int T2_TICKS = 1000;
	localparam int T3_TICKS = 1000;
	localparam int T4_TICKS = 4000;
	localparam int T5_TICKS = 4000;
	localparam int T6_TICKS = 1000;
	localparam int TIMER_W = 24;
	localparam int PULSE_W = 16;
	typedef enum logic [4:0] {
		WWD_POR = 5'b0_0001,
		WWD_SYNC = 5'b0_0010,
		WWD_CLOSED = 5'b0_0100,
		WWD_OPEN = 5'b0_1000,
		WWD_RESET = 5'b1_0000
	} wwd_state_type;
endpackage

/* shared/wwd_trig_if.sv */
`timescale 1ns/1ns
interface wwd_trig_if;
	logic tick;
	logic valid_trigger_pulse;
	logic trig_rise;
	logic trig_low;
	logic stuck_error;
	modport producer(output tick, output valid_trigger_pulse,
		output trig_rise, output trig_low, output stuck_error);
	modport consumer(input tick, input valid_trigger_pulse,
		input trig_rise, input trig_low, input stuck_error);
endinterface

/* design/wwd_trigger_qual.sv */
`timescale 1ns/1ns
module wwd_trigger_qual
	import wwd_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic trigger_in,
	wwd_trig_if.producer tq
);
	logic [2:0] sync;
	logic level;
	logic [15:0] div;
	logic [PULSE_W-1:0] width;
	logic [2:0] next_sync;
	logic next_level;
	logic [15:0] next_div;
	logic [PULSE_W-1:0] next_width;
	logic next_tick;
	logic next_valid;
	logic next_rise;
	logic next_err;

	always_comb begin
		next_sync = {sync[1:0], trigger_in};
		next_level = (sync[2] == sync[1]) ? sync[1] : level;
		next_tick = (div == 16'(TICK_CYCLES - 1));
		next_div = next_tick ? 16'h0000 : div + 16'h0001;
		next_width = width;
		if (!level && tq.tick && width != '1)
			next_width = width + 1'b1;
		if (level)
			next_width = '0;
		next_rise = !level && next_level;
		next_valid = next_rise && width >= PULSE_W'(PULSE_MIN_TICKS)
			&& width <= PULSE_W'(PULSE_MAX_TICKS);
		next_err = !level && width > PULSE_W'(PULSE_MAX_TICKS);
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			sync <= 3'b111;
			level <= 1'b1;
			div <= 16'h0000;
			width <= '0;
			tq.tick <= 1'b0;
			tq.valid_trigger_pulse <= 1'b0;
			tq.trig_rise <= 1'b0;
			tq.stuck_error <= 1'b0;
		end else begin
			sync <= next_sync;
			level <= next_level;
			div <= next_div;
			width <= next_width;
			tq.tick <= next_tick;
			tq.valid_trigger_pulse <= next_valid;
			tq.trig_rise <= next_rise;
			tq.stuck_error <= next_err;
		end
	end
	assign tq.trig_low = !level;
endmodule // wwd_trigger_qual

/* design/wwd_window_watchdog.sv */
`timescale 1ns/1ns
// Summary of operation
// - valid pulse in sync window starts supervision
// - valid pulse is low 10us to 5ms
// - no pulse in t1 gives reset
// - trigger in closed window gives reset
// - trigger in open window restarts closed
// - no trigger in closed+open gives reset
// - mode low short, high long
// - mode rising moves to long windows
// - mode falling moves to short windows
// - disable low stops trigger supervision
// - floating disable reads as enabled
// - trigger low too long is error
// - error holds reset until trigger high, only while disable is high
// - rising edge during reset restarts t6
// - power-up holds reset for t0
module wwd_window_watchdog
	import wwd_pkg::*;
#(
	parameter int T0 = T0_TICKS,
	parameter int T1 = T1_TICKS,
	parameter int T2 = T2_TICKS,
	parameter int T3 = T3_TICKS,
	parameter int T4 = T4_TICKS,
	parameter int T5 = T5_TICKS,
	parameter int T6 = T6_TICKS
)(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic supply_ok,
	input wire logic trigger_in,
	input wire logic mode,
	input wire logic watchdog_disable_n,
	output logic reset_out,
	output logic long_mode
);
	wwd_trig_if tq();
	wwd_state_type state;
	wwd_state_type next_state;
	logic [TIMER_W-1:0] timer;
	logic [TIMER_W-1:0] next_timer;
	logic [2:0] mode_s;
	logic [2:0] dis_s;
	logic [2:0] sup_s;
	logic mode_f;
	logic en_f;
	logic sup_f;
	logic next_mode_f;
	logic next_en_f;
	logic next_sup_f;
	logic next_reset_out;

	wwd_trigger_qual u_qual (
		.clk(clk),
		.reset_n(reset_n),
		.trigger_in(trigger_in),
		.tq(tq)
	);

	////////////////////////////////////////////////////////////////////
	// pin filters
	always_comb begin
		next_mode_f = (mode_s[2] == mode_s[1]) ? mode_s[1] : mode_f;
		next_en_f = (dis_s[2] == dis_s[1]) ? dis_s[1] : en_f;
		next_sup_f = (sup_s[2] == sup_s[1]) ? sup_s[1] : sup_f;
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			mode_s <= 3'b000;
			dis_s <= 3'b111;
			sup_s <= 3'b000;
			mode_f <= 1'b0;
			en_f <= 1'b1;
			sup_f <= 1'b0;
		end else begin
			mode_s <= {mode_s[1:0], mode};
			dis_s <= {dis_s[1:0], watchdog_disable_n};
			sup_s <= {sup_s[1:0], supply_ok};
			mode_f <= next_mode_f;
			en_f <= next_en_f;
			sup_f <= next_sup_f;
		end
	end

	////////////////////////////////////////////////////////////////////
	// window lengths follow the live mode level
	function automatic logic [TIMER_W-1:0] closed_len(input logic lm);
		closed_len = lm ? TIMER_W'(T4) : TIMER_W'(T2);
	endfunction

	function automatic logic [TIMER_W-1:0] open_len(input logic lm);
		open_len = lm ? TIMER_W'(T5) : TIMER_W'(T3);
	endfunction

	////////////////////////////////////////////////////////////////////
	// supervision state machine
	always_comb begin
		next_state = state;
		next_timer = timer;
		if (tq.tick && timer != '0)
			next_timer = timer - 1'b1;
		unique case (state)
		WWD_POR: begin
			if (!sup_f) begin
				next_timer = TIMER_W'(T0);
			end else if (timer == '0) begin
				next_state = WWD_SYNC;
				next_timer = TIMER_W'(T1);
			end
		end
		WWD_SYNC: begin
			if (tq.valid_trigger_pulse) begin
				next_state = WWD_CLOSED;
				next_timer = closed_len(mode_f);
			end else if (timer == '0) begin
				next_state = WWD_RESET;
				next_timer = TIMER_W'(T6);
			end
		end
		WWD_CLOSED: begin
			if (tq.valid_trigger_pulse) begin
				next_state = WWD_RESET;
				next_timer = TIMER_W'(T6);
			end else if (mode_f != long_mode) begin
				next_timer = closed_len(mode_f);
			end else if (timer == '0) begin
				next_state = WWD_OPEN;
				next_timer = open_len(mode_f);
			end
		end
		WWD_OPEN: begin
			if (tq.valid_trigger_pulse) begin
				next_state = WWD_CLOSED;
				next_timer = closed_len(mode_f);
			end else if (mode_f != long_mode) begin
				next_timer = open_len(mode_f);
			end else if (timer == '0) begin
				next_state = WWD_RESET;
				next_timer = TIMER_W'(T6);
			end
		end
		WWD_RESET: begin
			if (tq.trig_rise) begin
				next_timer = TIMER_W'(T6);
			end else if (timer == '0 && !tq.trig_low) begin
				next_state = WWD_SYNC;
				next_timer = TIMER_W'(T1);
			end
		end
		default: begin
			next_state = WWD_POR;
			next_timer = TIMER_W'(T0);
		end
		endcase
		if (!sup_f) begin
			next_state = WWD_POR;
			next_timer = TIMER_W'(T0);
		end else if (!en_f && state != WWD_POR) begin
			next_state = WWD_SYNC;
			next_timer = TIMER_W'(T1);
		end
		next_reset_out = !(next_state == WWD_POR
			|| next_state == WWD_RESET);
		if (tq.stuck_error && en_f)
			next_reset_out = 1'b0;
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state <= WWD_POR;
			timer <= TIMER_W'(T0);
			reset_out <= 1'b0;
			long_mode <= 1'b0;
		end else begin
			state <= next_state;
			timer <= next_timer;
			reset_out <= next_reset_out;
			long_mode <= mode_f;
		end
	end
endmodule // wwd_window_watchdog

/* testbench/wwd_chk.sv */
`timescale 1ns/1ns
module wwd_chk
	import wwd_pkg::*;
#(parameter int T1 = T1_TICKS, parameter int T4 = T4_TICKS,
	parameter int T5 = T5_TICKS)(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic supply_ok,
	input wire logic trigger_in,
	input wire logic mode,
	input wire logic watchdog_disable_n,
	input wire logic reset_out,
	input wire logic long_mode
);
	// longest quiet high stretch: sync, then a mode-restarted window
	localparam int LIM = (T1 + 2 * (T4 + T5) + 4) * TICK_CYCLES;
	int hi_cnt;
	int next_hi_cnt;
	always_comb begin
		next_hi_cnt = (reset_out && trigger_in && watchdog_disable_n) ?
			hi_cnt + 1 : 0;
	end
	always_ff @(posedge clk) begin
		hi_cnt <= reset_n ? next_hi_cnt : 0;
	end
	////////////////////////////////////////////////////////////
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	sequence s_low;
		!reset_out [*8];
	endsequence
	sequence s_mode_held;
		$stable(mode) [*8];
	endsequence
	AST_RST_HOLD: assert property ($rose(reset_n) |-> !long_mode)
		else $error("long_mode high after reset");
	AST_POR_HOLD: assert property ($rose(reset_n) |-> s_low)
		else $error("reset_out short after reset");
	AST_LOW_MIN: assert property ($fell(reset_out) |-> s_low)
		else $error("reset pulse too short");
	AST_RISE_SUPPLY: assert property ($rose(reset_out) |-> supply_ok)
		else $error("reset_out rose without supply");
	AST_RISE_TRIG: assert property ($rose(reset_out) |->
		$past(trigger_in, 6)) else $error("reset_out rose while trigger low");
	AST_DIS_QUIET: assert property ($fell(reset_out) |->
		$past(watchdog_disable_n, 8)) else $error("reset while disabled");
	AST_MODE_FOLLOW: assert property (s_mode_held |->
		long_mode == mode) else $error("long_mode does not follow mode");
	AST_HIGH_MAX: assert property (hi_cnt < LIM)
		else $error("no timeout reset");
endmodule // wwd_chk
bind wwd_window_watchdog wwd_chk #(.T1(T1), .T4(T4), .T5(T5)) chk (
	.clk(clk), .reset_n(reset_n), .supply_ok(supply_ok),
	.trigger_in(trigger_in), .mode(mode),
	.watchdog_disable_n(watchdog_disable_n), .reset_out(reset_out),
	.long_mode(long_mode));

/* testbench/wwd_mcu_model.sv */
`timescale 1ns/1ns
module wwd_mcu_model
	import wwd_pkg::*;
(
	input wire logic clk,
	input wire logic fire,
	input wire logic [7:0] width,
	output logic trigger_in
);
	initial trigger_in = 1'h1;
	// one low pulse per request, width in whole ticks
	always @(posedge clk) begin
		if (fire) begin
			#1 trigger_in = 1'h0;
			repeat (width * TICK_CYCLES) @(posedge clk);
			#1 trigger_in = 1'h1;
		end
	end
endmodule // wwd_mcu_model

/* testbench/tb_window_watchdog_fsm.sv */
`timescale 1ns/1ns
module tb_window_watchdog_fsm;
	import wwd_pkg::*;
	localparam int TC = TICK_CYCLES;
	// short window lengths keep the run inside its cycle budget
	localparam int TB_T0 = 2;
	localparam int TB_T1 = 5;
	localparam int TB_T2 = 3;
	localparam int TB_T3 = 6;
	localparam int TB_T4 = 6;
	localparam int TB_T5 = 6;
	localparam int TB_T6 = 2;
	logic clk, reset_n, supply_ok, mode, dis_n, fire, trig, rst_o, lm;
	logic [7:0] width;
	int bad_count = 0;
	int tests_run = 0;
	int n;
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	wwd_window_watchdog #(.T0(TB_T0), .T1(TB_T1), .T2(TB_T2), .T3(TB_T3),
		.T4(TB_T4), .T5(TB_T5), .T6(TB_T6)) dut (.clk(clk),
		.reset_n(reset_n), .supply_ok(supply_ok),
		.trigger_in(trig), .mode(mode), .watchdog_disable_n(dis_n),
		.reset_out(rst_o), .long_mode(lm));
	wwd_mcu_model mcu (.clk(clk), .fire(fire), .width(width),
		.trigger_in(trig));
	////////////////////////////////////////////////////////////
	task print_verdict;
		$display("bad_count=%0d tests_run=%0d", bad_count, tests_run);
		if (bad_count == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task check(input logic got, input logic exp, input string m);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask
	task check_n(input int lo, input int hi, input string m);
		check(n >= lo && n <= hi, 1'h1, m);
	endtask
	task wait_out(input logic lvl, input int lim);
		n = 0;
		while (rst_o !== lvl) begin
			@(posedge clk);
			#1 n++;
			if (n > lim * TC) begin
				bad_count++;
				$display("[ERR] %0t wait timed out", $time);
				print_verdict;
			end
		end
	endtask
	task pulse(input int w);
		width = 8'(w);
		fire = 1'h1;
		@(posedge clk);
		#1 fire = 1'h0;
		repeat (w * TC + 8) @(posedge clk);
		#1;
	endtask
	task t_power;
		check(rst_o, 1'h0, "reset_out high at power");
		supply_ok = 1'h1;
		wait_out(1'h1, TB_T0 + 2);
		check_n((TB_T0 - 1) * TC,
			(TB_T0 + 1) * TC + 20, "t0 length");
	endtask
	task t_sync_lost;
		wait_out(1'h0, TB_T1 + 2);
		check_n((TB_T1 - 1) * TC,
			(TB_T1 + 1) * TC + 20, "t1 length");
		wait_out(1'h1, TB_T6 + 2);
		check_n((TB_T6 - 1) * TC,
			(TB_T6 + 1) * TC + 20, "t6 length");
	endtask
	task t_open_ok;
		pulse(1);
		repeat ((TB_T2 + 1) * TC) @(posedge clk);
		#1;
		pulse(1);
		check(rst_o, 1'h1, "open trigger refused");
		wait_out(1'h0, TB_T2 + TB_T3 + 2);
		check_n((TB_T2 + TB_T3 - 1) * TC - 20,
			(TB_T2 + TB_T3 + 1) * TC + 20, "t2+t3 length");
		wait_out(1'h1, TB_T6 + 2);
	endtask
	task t_closed_bad;
		pulse(1);
		pulse(1);
		check(rst_o, 1'h0, "closed trigger accepted");
		// pulse outlasts the reset timer, so trigger low holds it low and the rise restarts t6
		pulse(TB_T6);
		wait_out(1'h1, TB_T6 + 2);
		check_n((TB_T6 - 1) * TC - 20,
			(TB_T6 + 1) * TC + 20, "t6 after rise");
	endtask
	task t_modes;
		pulse(1);
		mode = 1'h1;
		wait_out(1'h0, TB_T4 + TB_T5 + 2);
		check_n((TB_T4 + TB_T5 - 2) * TC + 500,
			(TB_T4 + TB_T5 + 1) * TC + 20, "long windows");
		check(lm, 1'h1, "long_mode low");
		wait_out(1'h1, TB_T6 + 2);
		pulse(1);
		mode = 1'h0;
		wait_out(1'h0, TB_T2 + TB_T3 + 2);
		check_n((TB_T2 + TB_T3 - 2) * TC,
			(TB_T2 + TB_T3 + 1) * TC + 20, "short windows");
		check(lm, 1'h0, "long_mode high");
		wait_out(1'h1, TB_T6 + 2);
	endtask
	task t_disable;
		dis_n = 1'h0;
		n = 0;
		repeat ((TB_T1 + 3) * TC) begin
			@(posedge clk);
			#1 n += int'(rst_o !== 1'h1);
		end
		check_n(0, 0, "reset while disabled");
		dis_n = 1'h1;
		wait_out(1'h0, TB_T1 + 2);
		check_n((TB_T1 - 1) * TC,
			(TB_T1 + 1) * TC + 20, "sync after enable");
	endtask
	initial begin
		reset_n = 1'h0;
		supply_ok = 1'h0;
		mode = 1'h0;
		dis_n = 1'h1;
		fire = 1'h0;
		width = 8'h00;
		repeat (2) @(posedge clk);
		#1 reset_n = 1'h1;
		t_power;
		t_sync_lost;
		t_open_ok;
		t_closed_bad;
		t_modes;
		t_disable;
		print_verdict;
	end
endmodule // tb_window_watchdog_fsm
